// [design/bpc_params.svh]
// Register offsets, field positions, reset values and frame sizes of the bias and power bank.
// Assumes an includer that works on 16-bit words reached by a 9-bit serial address.
// How it works
// - Frontend power enable in bit zero
// - Bandgap power enable, bit zero, address 64
// - Resistor select bit zero, defaults external
// - Bias word resets 0x888B, trim, precharge
// - Column bias bits 11:8, reserved nibble 8
// - Mux word 0x8888, stage, stage, delay nibbles
// - Common-mode buffer bias in bits 15:12
// - Frontend power word at 48, resets zero
`ifndef BPC_PARAMS_SVH
`define BPC_PARAMS_SVH

// Serial frame layout
`define BPC_ADDR_BITS 9
`define BPC_DATA_BITS 16
`define BPC_FRAME_BITS 26

// Block offsets
`define BPC_FRONTEND_BLOCK 9'h030
`define BPC_BIAS_BLOCK 9'h040
`define BPC_TEST_BLOCK 9'h050

// Register addresses
`define BPC_ADDR_FRONTEND_POWER 9'h030
`define BPC_ADDR_BANDGAP_POWER 9'h040
`define BPC_ADDR_BIAS_GENERAL 9'h041
`define BPC_ADDR_FRONTEND_BIAS 9'h042
`define BPC_ADDR_COLMUX_BIAS 9'h043
`define BPC_ADDR_SERIAL_DRIVER_BIAS 9'h044
`define BPC_ADDR_BIAS_SPARE 9'h046
`define BPC_ADDR_TEST_SPARE_ZERO 9'h050
`define BPC_ADDR_TEST_SPARE_ONE 9'h051
`define BPC_ADDR_TEST_SPARE_SIXTEEN 9'h060
`define BPC_ADDR_TEST_SPARE_READONLY 9'h061

// Reset values
`define BPC_RST_FRONTEND_POWER 16'h0000
`define BPC_RST_BANDGAP_POWER 16'h0000
`define BPC_RST_BIAS_GENERAL 16'h888B
`define BPC_RST_FRONTEND_BIAS 16'h53C8
`define BPC_RST_COLMUX_BIAS 16'h8888
`define BPC_RST_SERIAL_DRIVER_BIAS 16'h0088
`define BPC_RST_BIAS_SPARE 16'h8888
`define BPC_RST_TEST_SPARE 16'h0000
`define BPC_READONLY_VALUE 16'h0000

// Field positions
`define BPC_POWER_EN_BIT 0
`define BPC_EXTRES_BIT 0
`define BPC_BGTRIM_LSB 1
`define BPC_BGTRIM_MSB 3
`define BPC_NIB0_LSB 0
`define BPC_NIB0_MSB 3
`define BPC_NIB1_LSB 4
`define BPC_NIB1_MSB 7
`define BPC_NIB2_LSB 8
`define BPC_NIB2_MSB 11
`define BPC_NIB3_LSB 12
`define BPC_NIB3_MSB 15
`define BPC_PGA_LSB 8
`define BPC_PGA_MSB 14

`endif

// [design/bpc_pkg.sv]
// Types shared by the bias and power register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package bpc_pkg;

  typedef logic [8:0] bpc_addr_t;
  typedef logic [15:0] bpc_word_t;

  // Gray along idle, address, data, done
  typedef enum logic [1:0]
  {
    BPC_IDLE = 2'h0,
    BPC_ADDR = 2'h1,
    BPC_DATA = 2'h3,
    BPC_DONE = 2'h2
  } bpc_state_t;

endpackage

// [design/bpc_link_if.sv]
// Synchronised serial events passed from the pin stage to the frame logic.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface bpc_link_if;
  logic sck_rise;
  logic sck_fall;
  logic cs_active;
  logic mosi_bit;

  modport drv
  (
    output sck_rise,
    output sck_fall,
    output cs_active,
    output mosi_bit
  );
  modport mon
  (
    input sck_rise,
    input sck_fall,
    input cs_active,
    input mosi_bit
  );
endinterface

// [design/bpc_pin_sync.sv]
// Two-stage synchronisers and clock edge detection for the serial pins.
// Assumes each serial clock phase lasts at least three system clocks.
`timescale 1ns/1ps
module bpc_pin_sync
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Serial pins
  input wire logic spi_sck_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  // Events
  bpc_link_if.drv lnk
);
  logic [1:0] sck_sync_reg;
  logic [1:0] cs_n_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic sck_prev_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      sck_sync_reg <= 2'h0;
      cs_n_sync_reg <= 2'h3;
      mosi_sync_reg <= 2'h0;
      sck_prev_reg <= 1'b0;
    end
    else
    begin
      sck_sync_reg <= {sck_sync_reg[0], spi_sck_in};
      cs_n_sync_reg <= {cs_n_sync_reg[0], spi_cs_n_in};
      mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi_in};
      sck_prev_reg <= sck_sync_reg[1];
    end
  end

  assign lnk.sck_rise = sck_sync_reg[1] & ~sck_prev_reg;
  assign lnk.sck_fall = ~sck_sync_reg[1] & sck_prev_reg;
  assign lnk.cs_active = ~cs_n_sync_reg[1];
  assign lnk.mosi_bit = mosi_sync_reg[1];
endmodule

// [design/bpc_reg_word.sv]
// One read-write configuration word with its own reset value.
// Assumes a write strobe already decoded for this word.
`timescale 1ns/1ps
module bpc_reg_word
#(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Write side
  input wire logic wr_en_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Stored value
  output logic [WIDTH-1:0] value_out
);
  logic [WIDTH-1:0] value_reg;

  // Whole word stored, reserved bits included
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      value_reg <= RESET_VALUE;
    else if (wr_en_in)
      value_reg <= wr_data_in;
  end

  assign value_out = value_reg;
endmodule

// [design/bpc_bias_power_regs.sv]
// Bias generator and power configuration bank behind the serial register port.
// Assumes mode-0 style serial timing with each clock phase at least three system clocks long.
`timescale 1ns/1ps
`include "bpc_params.svh"
module bpc_bias_power_regs
  import bpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Serial register port
  input wire logic spi_sck_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  // Power enables
  output logic frontend_power_enable_out,
  output logic bandgap_power_enable_out,
  // General bias setup
  output logic external_resistor_sel_out,
  output logic [2:0] bandgap_trim_out,
  output logic [3:0] column_precharge_ibias_out,
  output logic [3:0] column_bias_ibias_out,
  output logic [3:0] bias_general_spare_out,
  // Frontend bias setup
  output logic [3:0] frontend_ibias_out,
  output logic [3:0] converter_iref_out,
  output logic [6:0] gain_amp_iref_out,
  // Column multiplexer bias setup
  output logic [3:0] colmux_first_stage_bias_out,
  output logic [3:0] colmux_second_stage_bias_out,
  output logic [3:0] colmux_delay_bias_out,
  output logic [3:0] colmux_common_mode_bias_out,
  // Serial driver bias setup
  output logic [3:0] serial_driver_ibias_out,
  output logic [3:0] serial_driver_iref_out,
  // Spare words
  output logic [15:0] bias_spare_word_out,
  output logic [15:0] test_spare_zero_out,
  output logic [15:0] test_spare_one_out,
  output logic [15:0] test_spare_sixteen_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register table

  localparam int NUM_WORDS = 10;
  localparam int ADDR_BITS = `BPC_ADDR_BITS;
  localparam int DATA_BITS = `BPC_DATA_BITS;
  localparam int FRAME_BITS = `BPC_FRAME_BITS;
  localparam logic [4:0] RW_BIT_INDEX = 5'(ADDR_BITS);
  localparam logic [4:0] LAST_BIT_INDEX = 5'(FRAME_BITS - 1);

  // Addresses are block offset plus word offset
  localparam bpc_addr_t ADDR_TAB [NUM_WORDS] = '{
    `BPC_ADDR_FRONTEND_POWER,
    `BPC_ADDR_BANDGAP_POWER,
    `BPC_ADDR_BIAS_GENERAL,
    `BPC_ADDR_FRONTEND_BIAS,
    `BPC_ADDR_COLMUX_BIAS,
    `BPC_ADDR_SERIAL_DRIVER_BIAS,
    `BPC_ADDR_BIAS_SPARE,
    `BPC_ADDR_TEST_SPARE_ZERO,
    `BPC_ADDR_TEST_SPARE_ONE,
    `BPC_ADDR_TEST_SPARE_SIXTEEN
  };

  localparam bpc_word_t RESET_TAB [NUM_WORDS] = '{
    `BPC_RST_FRONTEND_POWER,
    `BPC_RST_BANDGAP_POWER,
    `BPC_RST_BIAS_GENERAL,
    `BPC_RST_FRONTEND_BIAS,
    `BPC_RST_COLMUX_BIAS,
    `BPC_RST_SERIAL_DRIVER_BIAS,
    `BPC_RST_BIAS_SPARE,
    `BPC_RST_TEST_SPARE,
    `BPC_RST_TEST_SPARE,
    `BPC_RST_TEST_SPARE
  };

  localparam int IDX_FRONTEND_POWER = 0;
  localparam int IDX_BANDGAP_POWER = 1;
  localparam int IDX_BIAS_GENERAL = 2;
  localparam int IDX_FRONTEND_BIAS = 3;
  localparam int IDX_COLMUX_BIAS = 4;
  localparam int IDX_SERIAL_DRIVER_BIAS = 5;
  localparam int IDX_BIAS_SPARE = 6;
  localparam int IDX_TEST_SPARE_ZERO = 7;
  localparam int IDX_TEST_SPARE_ONE = 8;
  localparam int IDX_TEST_SPARE_SIXTEEN = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  bpc_link_if lnk();

  bpc_state_t state_reg;
  logic [4:0] bit_cnt_reg;
  bpc_addr_t addr_reg;
  logic write_reg;
  logic [DATA_BITS-2:0] data_reg;
  bpc_word_t tx_reg;
  logic miso_reg;
  logic miso_oe_reg;
  logic commit;
  bpc_word_t commit_data;
  bpc_addr_t rd_addr;
  bpc_word_t words [NUM_WORDS];
  logic [NUM_WORDS-1:0] word_wr_en;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and readback

  // One-hot select, empty for unmapped and read-only addresses
  function automatic logic [NUM_WORDS-1:0] decode_word(input bpc_addr_t addr);
    logic [NUM_WORDS-1:0] hit;
    hit = '0;
    for (int i = 0; i < NUM_WORDS; i++)
    begin
      if (addr == ADDR_TAB[i])
        hit[i] = 1'b1;
    end
    return hit;
  endfunction

  // Unmapped addresses read zero rather than stale data
  function automatic bpc_word_t read_word(input bpc_addr_t addr, input bpc_word_t vals [NUM_WORDS]);
    bpc_word_t result;
    logic [NUM_WORDS-1:0] hit;
    result = '0;
    hit = decode_word(addr);
    if (addr == `BPC_ADDR_TEST_SPARE_READONLY)
      result = `BPC_READONLY_VALUE;
    else
    begin
      for (int i = 0; i < NUM_WORDS; i++)
      begin
        if (hit[i])
          result = vals[i];
      end
    end
    return result;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  bpc_pin_sync u_pin_sync
  (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .spi_sck_in(spi_sck_in),
    .spi_cs_n_in(spi_cs_n_in),
    .spi_mosi_in(spi_mosi_in),
    .lnk(lnk.drv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencing

  // Chip select release aborts any frame in progress
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      state_reg <= BPC_IDLE;
    else if (!lnk.cs_active)
      state_reg <= BPC_IDLE;
    else
    begin
      case (state_reg)
        BPC_IDLE:
          state_reg <= BPC_ADDR;
        BPC_ADDR:
          if (lnk.sck_rise && bit_cnt_reg == RW_BIT_INDEX)
            state_reg <= BPC_DATA;
        BPC_DATA:
          if (lnk.sck_rise && bit_cnt_reg == LAST_BIT_INDEX)
            state_reg <= BPC_DONE;
        BPC_DONE:
          state_reg <= BPC_DONE;
        default:
          state_reg <= BPC_IDLE;
      endcase
    end
  end

  // Extra clocks after the last data bit are ignored
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      bit_cnt_reg <= 5'h00;
    else if (!lnk.cs_active)
      bit_cnt_reg <= 5'h00;
    else if (lnk.sck_rise && state_reg != BPC_DONE && state_reg != BPC_IDLE)
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      addr_reg <= '0;
    else if (state_reg == BPC_ADDR && lnk.sck_rise && bit_cnt_reg < RW_BIT_INDEX)
      addr_reg <= {addr_reg[ADDR_BITS-2:0], lnk.mosi_bit};
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      write_reg <= 1'b0;
    else if (state_reg == BPC_ADDR && lnk.sck_rise && bit_cnt_reg == RW_BIT_INDEX)
      write_reg <= lnk.mosi_bit;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      data_reg <= '0;
    else if (state_reg == BPC_DATA && lnk.sck_rise)
      data_reg <= {data_reg[DATA_BITS-3:0], lnk.mosi_bit};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write commit

  // Only a full 16-bit data phase writes; a short frame changes nothing
  assign commit = state_reg == BPC_DATA && lnk.sck_rise && bit_cnt_reg == LAST_BIT_INDEX && write_reg;
  assign commit_data = {data_reg, lnk.mosi_bit};
  assign word_wr_en = commit ? decode_word(addr_reg) : '0;

  for (genvar g = 0; g < NUM_WORDS; g++)
  begin : g_word
    bpc_reg_word
    #(
      .WIDTH(DATA_BITS),
      .RESET_VALUE(RESET_TAB[g])
    )
    u_word
    (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .wr_en_in(word_wr_en[g]),
      .wr_data_in(commit_data),
      .value_out(words[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback shifter

  assign rd_addr = {addr_reg[ADDR_BITS-2:0], lnk.mosi_bit};

  // Snapshot taken at the last address bit so a later write cannot tear the word
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      tx_reg <= '0;
    else if (state_reg == BPC_ADDR && lnk.sck_rise && bit_cnt_reg == RW_BIT_INDEX - 5'h01)
      tx_reg <= read_word(rd_addr, words);
    else if (state_reg == BPC_DATA && lnk.sck_fall && !write_reg)
      tx_reg <= {tx_reg[DATA_BITS-2:0], 1'b0};
  end

  // Data changes on the falling clock so the host samples it on the rising one
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      miso_reg <= 1'b0;
    else if (!lnk.cs_active)
      miso_reg <= 1'b0;
    else if (state_reg == BPC_DATA && lnk.sck_fall && !write_reg)
      miso_reg <= tx_reg[DATA_BITS-1];
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      miso_oe_reg <= 1'b0;
    else
      // Held through done so the last read bit never stands on an undriven pin
      miso_oe_reg <= lnk.cs_active && (state_reg == BPC_DATA || state_reg == BPC_DONE) && !write_reg;
  end

  assign spi_miso_out = miso_reg;
  assign spi_miso_oe_out = miso_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Static control fields

  assign frontend_power_enable_out = words[IDX_FRONTEND_POWER][`BPC_POWER_EN_BIT];
  assign bandgap_power_enable_out = words[IDX_BANDGAP_POWER][`BPC_POWER_EN_BIT];

  assign external_resistor_sel_out = words[IDX_BIAS_GENERAL][`BPC_EXTRES_BIT];
  assign bandgap_trim_out = words[IDX_BIAS_GENERAL][`BPC_BGTRIM_MSB:`BPC_BGTRIM_LSB];
  assign column_precharge_ibias_out = words[IDX_BIAS_GENERAL][`BPC_NIB1_MSB:`BPC_NIB1_LSB];
  assign column_bias_ibias_out = words[IDX_BIAS_GENERAL][`BPC_NIB2_MSB:`BPC_NIB2_LSB];
  assign bias_general_spare_out = words[IDX_BIAS_GENERAL][`BPC_NIB3_MSB:`BPC_NIB3_LSB];

  assign frontend_ibias_out = words[IDX_FRONTEND_BIAS][`BPC_NIB0_MSB:`BPC_NIB0_LSB];
  assign converter_iref_out = words[IDX_FRONTEND_BIAS][`BPC_NIB1_MSB:`BPC_NIB1_LSB];
  assign gain_amp_iref_out = words[IDX_FRONTEND_BIAS][`BPC_PGA_MSB:`BPC_PGA_LSB];

  assign colmux_first_stage_bias_out = words[IDX_COLMUX_BIAS][`BPC_NIB0_MSB:`BPC_NIB0_LSB];
  assign colmux_second_stage_bias_out = words[IDX_COLMUX_BIAS][`BPC_NIB1_MSB:`BPC_NIB1_LSB];
  assign colmux_delay_bias_out = words[IDX_COLMUX_BIAS][`BPC_NIB2_MSB:`BPC_NIB2_LSB];
  assign colmux_common_mode_bias_out = words[IDX_COLMUX_BIAS][`BPC_NIB3_MSB:`BPC_NIB3_LSB];

  assign serial_driver_ibias_out = words[IDX_SERIAL_DRIVER_BIAS][`BPC_NIB0_MSB:`BPC_NIB0_LSB];
  assign serial_driver_iref_out = words[IDX_SERIAL_DRIVER_BIAS][`BPC_NIB1_MSB:`BPC_NIB1_LSB];

  // Spares are stored only; their analog meaning is not defined here
  assign bias_spare_word_out = words[IDX_BIAS_SPARE];
  assign test_spare_zero_out = words[IDX_TEST_SPARE_ZERO];
  assign test_spare_one_out = words[IDX_TEST_SPARE_ONE];
  assign test_spare_sixteen_out = words[IDX_TEST_SPARE_SIXTEEN];

endmodule

// [test/bpc_bias_power_regs_monitor.sv]
// Concurrent checks on the ports of the bias and power register bank.
// Assumes the bank's top module and one system clock; bound at the foot of this file.
`timescale 1ns/1ps
module bpc_bias_power_regs_monitor
(
  // Clock, reset and serial pins
  input wire logic clk_sys_in, reset_in, spi_cs_n_in, spi_miso_out, spi_miso_oe_out,
  // Field outputs
  input wire logic frontend_power_enable_out, bandgap_power_enable_out, external_resistor_sel_out,
  input wire logic [2:0] bandgap_trim_out,
  input wire logic [3:0] column_precharge_ibias_out, column_bias_ibias_out, bias_general_spare_out,
  input wire logic [3:0] frontend_ibias_out, converter_iref_out,
  input wire logic [6:0] gain_amp_iref_out,
  input wire logic [3:0] colmux_first_stage_bias_out, colmux_second_stage_bias_out,
  input wire logic [3:0] colmux_delay_bias_out, colmux_common_mode_bias_out,
  input wire logic [3:0] serial_driver_ibias_out, serial_driver_iref_out,
  input wire logic [15:0] bias_spare_word_out, test_spare_zero_out, test_spare_one_out, test_spare_sixteen_out
);
  logic [3:0] cs_high_cnt_reg;
  logic [15:0] general_word;
  logic [15:0] colmux_word;
  logic [14:0] frontend_word;
  logic [7:0] driver_word;
  logic [63:0] spare_words;
  logic [120:0] all_fields;

  assign general_word = {bias_general_spare_out, column_bias_ibias_out, column_precharge_ibias_out,
                         bandgap_trim_out, external_resistor_sel_out};
  assign colmux_word = {colmux_common_mode_bias_out, colmux_delay_bias_out, colmux_second_stage_bias_out,
                        colmux_first_stage_bias_out};
  assign frontend_word = {gain_amp_iref_out, converter_iref_out, frontend_ibias_out};
  assign driver_word = {serial_driver_iref_out, serial_driver_ibias_out};
  assign spare_words = {bias_spare_word_out, test_spare_zero_out, test_spare_one_out, test_spare_sixteen_out};
  assign all_fields = {frontend_power_enable_out, bandgap_power_enable_out, general_word, colmux_word,
                       frontend_word, driver_word, spare_words};

  // Saturating count of idle select; nine clears the pin synchronisers with margin
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || spi_cs_n_in == 1'b0)
      cs_high_cnt_reg <= 4'h0;
    else if (cs_high_cnt_reg != 4'hF)
      cs_high_cnt_reg <= cs_high_cnt_reg + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys_in);
  endclocking

  property p_reset_power;
    reset_in |=> !frontend_power_enable_out && !bandgap_power_enable_out;
  endproperty
  a_reset_power: assert property (p_reset_power)
    else $error("power enables not cleared by reset");
  property p_reset_general;
    reset_in |=> general_word == 16'h888B;
  endproperty
  a_reset_general: assert property (p_reset_general)
    else $error("general bias fields wrong after reset");
  property p_reset_colmux;
    reset_in |=> colmux_word == 16'h8888;
  endproperty
  a_reset_colmux: assert property (p_reset_colmux)
    else $error("column mux fields wrong after reset");
  property p_reset_other;
    reset_in |=> frontend_word == 15'h53C8 && driver_word == 8'h88 && spare_words == 64'h8888_0000_0000_0000;
  endproperty
  a_reset_other: assert property (p_reset_other)
    else $error("other words wrong after reset");
  property p_idle_stable;
    disable iff (reset_in) cs_high_cnt_reg >= 4'h9 |-> $stable(all_fields);
  endproperty
  a_idle_stable: assert property (p_idle_stable)
    else $error("field output changed with no frame");
  property p_idle_quiet;
    disable iff (reset_in) cs_high_cnt_reg >= 4'h9 |-> !spi_miso_oe_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("data out enabled while deselected");
  property p_miso_quiet;
    disable iff (reset_in) !spi_miso_oe_out |-> !spi_miso_out;
  endproperty
  a_miso_quiet: assert property (p_miso_quiet)
    else $error("data out high while not driven");
  property p_select_start;
    disable iff (reset_in) $fell(spi_cs_n_in) && cs_high_cnt_reg >= 4'h9 |=> !spi_miso_oe_out [*8];
  endproperty
  a_select_start: assert property (p_select_start)
    else $error("data out enabled before address phase ended");
  property p_reset_miso;
    reset_in |=> !spi_miso_oe_out && !spi_miso_out;
  endproperty
  a_reset_miso: assert property (p_reset_miso)
    else $error("data out active after reset");

  c_power_up: cover property (disable iff (reset_in) $rose(frontend_power_enable_out));
  c_read: cover property (disable iff (reset_in) $rose(spi_miso_oe_out));
  c_colmux_write: cover property (disable iff (reset_in) !$stable(colmux_word));
endmodule

bind bpc_bias_power_regs bpc_bias_power_regs_monitor mon_u (.*);

// [test/test_bpc_bias_power_regs.sv]
// Self-checking bench for the bias and power register bank, driving the serial pins itself.
// Assumes the monitor file is compiled before it; one 125 MHz clock.
`timescale 1ns/1ps
module test_bpc_bias_power_regs import bpc_pkg::*;;
  logic clk_sys_in, reset_in, spi_sck_in, spi_cs_n_in, spi_mosi_in, spi_miso_out, spi_miso_oe_out;
  logic frontend_power_enable_out, bandgap_power_enable_out, external_resistor_sel_out;
  logic [2:0] bandgap_trim_out;
  logic [3:0] column_precharge_ibias_out, column_bias_ibias_out, bias_general_spare_out, frontend_ibias_out;
  logic [3:0] converter_iref_out, colmux_first_stage_bias_out, colmux_second_stage_bias_out;
  logic [3:0] colmux_delay_bias_out, colmux_common_mode_bias_out, serial_driver_ibias_out, serial_driver_iref_out;
  logic [6:0] gain_amp_iref_out;
  logic [15:0] bias_spare_word_out, test_spare_zero_out, test_spare_one_out, test_spare_sixteen_out;
  localparam bpc_addr_t ADR [10] = '{9'h030 + 9'h000, 9'h040 + 9'h000, 9'h040 + 9'h001, 9'h040 + 9'h002,
                                     9'h040 + 9'h003, 9'h040 + 9'h004, 9'h040 + 9'h006, 9'h050 + 9'h000,
                                     9'h050 + 9'h001, 9'h050 + 9'h010};
  localparam bpc_word_t RST [10] = '{16'h0000, 16'h0000, 16'h888B, 16'h53C8, 16'h8888, 16'h0088, 16'h8888,
                                     16'h0000, 16'h0000, 16'h0000};
  localparam bpc_word_t MSK [10] = '{16'h0001, 16'h0001, 16'hFFFF, 16'h7FFF, 16'hFFFF, 16'h00FF, 16'hFFFF,
                                     16'hFFFF, 16'hFFFF, 16'hFFFF};
  bpc_word_t model [10];
  int fail_count;
  int n_compared;
  logic [31:0] seed;

  bpc_bias_power_regs dut_u (.*);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Unmapped and read-only places read zero
  function automatic bpc_word_t exp_read(input bpc_addr_t a);
    for (int i = 0; i < 10; i++)
      if (ADR[i] == a)
        return model[i];
    return 16'h0000;
  endfunction

  function automatic bpc_word_t field_word(input int i);
    case (i)
      0: return {15'h0000, frontend_power_enable_out};
      1: return {15'h0000, bandgap_power_enable_out};
      2: return {bias_general_spare_out, column_bias_ibias_out, column_precharge_ibias_out, bandgap_trim_out,
                 external_resistor_sel_out};
      3: return {1'b0, gain_amp_iref_out, converter_iref_out, frontend_ibias_out};
      4: return {colmux_common_mode_bias_out, colmux_delay_bias_out, colmux_second_stage_bias_out,
                 colmux_first_stage_bias_out};
      5: return {8'h00, serial_driver_iref_out, serial_driver_ibias_out};
      6: return bias_spare_word_out;
      7: return test_spare_zero_out;
      8: return test_spare_one_out;
      default: return test_spare_sixteen_out;
    endcase
  endfunction

  task automatic chk(input string what, input bpc_word_t exp, input bpc_word_t got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Frames shorter than 26 bits are cut off by raising select
  task automatic xfer(input bpc_addr_t a, input logic wr, input bpc_word_t d, input int nbits, output bpc_word_t q);
    logic [25:0] f;
    f = {a, wr, d};
    q = 16'h0000;
    @(posedge clk_sys_in);
    spi_cs_n_in <= 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      repeat (5) @(posedge clk_sys_in);
      spi_mosi_in <= f[25-i];
      repeat (6) @(posedge clk_sys_in);
      if (i >= 10)
        q[25-i] = spi_miso_out;
      spi_sck_in <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      spi_sck_in <= 1'b0;
    end
    repeat (6) @(posedge clk_sys_in);
    spi_cs_n_in <= 1'b1;
    spi_mosi_in <= ~spi_mosi_in;
    repeat (12) @(posedge clk_sys_in);
  endtask

  task automatic wr_reg(input bpc_addr_t a, input bpc_word_t d);
    bpc_word_t q;
    xfer(a, 1'b1, d, 26, q);
    for (int i = 0; i < 10; i++)
      if (ADR[i] == a)
        model[i] = d;
  endtask

  task automatic rd_chk(input bpc_addr_t a);
    bpc_word_t q;
    xfer(a, 1'b0, 16'h0000, 26, q);
    chk("read word", exp_read(a), q);
  endtask

  task automatic check_fields();
    for (int i = 0; i < 10; i++)
      chk("field word", model[i] & MSK[i], field_word(i));
  endtask

  task automatic check_all(input string name);
    check_fields();
    for (int i = 0; i < 10; i++)
      rd_chk(ADR[i]);
    $display("test %s done", name);
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // About 83 frames of some 460 clocks each
  initial
  begin
    repeat (70000) @(posedge clk_sys_in);
    fail_count++;
    results();
  end

  initial
  begin
    bpc_word_t q;
    reset_in = 1'b1;
    spi_sck_in = 1'b0;
    spi_cs_n_in = 1'b1;
    spi_mosi_in = 1'b0;
    seed = 32'h0001814F;
    fail_count = 0;
    n_compared = 0;
    model = RST;
    repeat (16) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    check_all("defaults");
    for (int k = 0; k < 16; k++)
    begin
      seed = xorshift(seed);
      wr_reg(ADR[seed[19:16] % 4'hA], seed[15:0]);
      check_fields();
    end
    check_all("random");
    for (int k = 0; k < 10; k++)
      wr_reg(ADR[k], 16'hFFFF);
    check_all("ones");
    wr_reg(9'h061, 16'hFFFF);
    wr_reg(9'h045, 16'hA5A5);
    wr_reg(9'h1FF, 16'h5A5A);
    rd_chk(9'h061);
    rd_chk(9'h045);
    rd_chk(9'h1FF);
    xfer(9'h040, 1'b1, 16'h0000, 20, q);
    check_fields();
    $display("test refused done");
    for (int k = 0; k < 10; k++)
      wr_reg(ADR[k], 16'h0000);
    check_fields();
    @(posedge clk_sys_in);
    reset_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    model = RST;
    repeat (4) @(posedge clk_sys_in);
    check_all("second reset");
    results();
  end
endmodule
